// ---- hw/bus_timing_config_decode.sv ----
/*
 * Chip-period and second timing configuration registers with their decode.
 * Assumes register strobes and mode level synchronous to the 25 MHz core clock.
 */
// Function
// - DSI3 low codes set chip time, no slew.
// - DSI3 high codes give 2.5 to 5.0.
// - Command and diagnostic traffic use 5 us.
// - PSI5 bit time 5.3 or 8.0 us.
// - SPI/I2C chip period stored, no effect.
// - Second register covered by array checksum.
// - Second register accessible only in listed modes.
// - Nibble source picks serial or user data.
// - Nibble source inert outside PSI5 modes.
// - Training error flag after selected periods.
// - DSI3 runs capacitor test unless disabled.
// - Capacitor fault sets buffer undervoltage error while the DSI3 capacitor test runs.
// - Undervoltage error blocks disabling writes.
// - Capacitor disable inert in SPI/I2C/PSI5.
// - Fragment size selects 2/3 or 4/6.
// - Diagnostic enable works only in DSI3.
`timescale 1ns/10ps
`default_nettype none
module bus_timing_config_decode
	import timing_cfg_pkg::*;
#(
	parameter int TICK_CYCLES = OSC_PERIOD_CYCLES
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [2:0] mode_i,
	input wire logic traffic_periodic_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] serial_number_byte4_i,
	input wire logic [7:0] user_data_six_i,
	input wire logic [7:0] user_data_fourteen_i,
	input wire logic osc_train_run_i,
	input wire logic osc_train_clear_i,
	input wire logic cap_fault_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_err_o,
	output logic [6:0] period_tenths_o,
	output logic slew_en_o,
	output logic period_active_o,
	output logic [3:0] init2_d19_o,
	output logic [3:0] init2_d20_o,
	output logic osc_train_error_flag_o,
	output logic cap_test_run_o,
	output logic buffer_undervoltage_error_o,
	output logic diag_active_o,
	output logic [2:0] diag_cmd_bits_o,
	output logic [2:0] diag_resp_chips_o,
	output logic [7:0] rw_checksum_o
);
	logic [3:0] chip_period_select_reg;
	logic [7:0] timing_config_two_reg;
	logic [7:0] reg_rdata_reg;
	logic reg_err_reg;
	logic [6:0] period_tenths_reg;
	logic slew_en_reg;
	logic period_active_reg;
	logic [3:0] d19_reg;
	logic [3:0] d20_reg;
	logic cap_test_run_reg;
	logic uv_reg;
	logic diag_active_reg;
	logic [2:0] diag_cmd_reg;
	logic [2:0] diag_resp_reg;
	logic [7:0] checksum_reg;

	osc_timer_if osc_bus ();

	osc_train_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_osc_timer (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.tmr(osc_bus.timer)
	);

	assign osc_bus.run = osc_train_run_i;
	assign osc_bus.clear = osc_train_clear_i;
	assign osc_bus.sel = timing_config_two_reg[OSC_SEL_MSB:OSC_SEL_LSB];

	wire logic is_dsi3 = (mode_i == MODE_DSI3);
	wire logic is_psi5 = (mode_i == MODE_PSI5);
	wire logic is_psi5_any = is_psi5 || (mode_i == MODE_PSI5_PROG);
	wire logic access_ok = (mode_i == MODE_DSI3) || (mode_i == MODE_PSI5_PROG) ||
		(mode_i == MODE_SPI) || (mode_i == MODE_I2C);
	wire logic hit_cp = (reg_addr_i == ADDR_CHIP_PERIOD);
	wire logic hit_two = (reg_addr_i == ADDR_CFG_TWO);
	wire logic lock_block = uv_reg && reg_wdata_i[CAP_OFF_BIT] &&
		!timing_config_two_reg[CAP_OFF_BIT];
	wire logic wr_cp = reg_wr_i && access_ok && hit_cp;
	wire logic wr_two = reg_wr_i && access_ok && hit_two && !lock_block;
	wire logic refuse = (reg_wr_i || reg_rd_i) && (!access_ok || !(hit_cp || hit_two)) ||
		(reg_wr_i && access_ok && hit_two && lock_block);

	wire logic [3:0] chip_period_next = wr_cp ? reg_wdata_i[3:0] : chip_period_select_reg;
	wire logic [7:0] cfg_two_next = wr_two ? (reg_wdata_i & CFG_TWO_WMASK) :
		timing_config_two_reg;
	wire logic [7:0] read_mux = hit_cp ? {4'h0, chip_period_select_reg} :
		hit_two ? timing_config_two_reg : 8'h00;
	wire logic [7:0] rdata_next = (reg_rd_i && access_ok) ? read_mux : 8'h00;

	wire logic dsi3_slew = (chip_period_select_reg >= DSI3_SLEW_FIRST_CODE);
	wire logic [6:0] dsi3_tenths = traffic_periodic_i ?
		DSI3_CHIP_TENTHS[chip_period_select_reg] : CRM_CHIP_TENTHS;
	wire logic [6:0] psi5_tenths = chip_period_select_reg[3] ?
		PSI5_SLOW_TENTHS : PSI5_FAST_TENTHS;
	wire logic [6:0] period_next = is_dsi3 ? dsi3_tenths :
		is_psi5 ? psi5_tenths : 7'h00;
	wire logic slew_next = is_dsi3 ? (!traffic_periodic_i || dsi3_slew) : is_psi5;
	wire logic active_next = is_dsi3 || is_psi5;

	wire logic nib_user = timing_config_two_reg[NIBBLE_SRC_BIT];
	wire logic [3:0] d19_next = !is_psi5_any ? 4'h0 :
		nib_user ? user_data_six_i[7:4] : serial_number_byte4_i[7:4];
	wire logic [3:0] d20_next = !is_psi5_any ? 4'h0 :
		nib_user ? user_data_fourteen_i[7:4] : serial_number_byte4_i[3:0];

	wire logic cap_run_next = is_dsi3 && !timing_config_two_reg[CAP_OFF_BIT];
	// The error follows the fault level, so it clears when the fault recovers.
	wire logic uv_next = cap_fault_i && cap_run_next;

	wire logic diag_large = timing_config_two_reg[FRAG_SIZE_BIT];
	wire logic diag_next = is_dsi3 && timing_config_two_reg[DIAG_EN_BIT];
	wire logic [2:0] diag_cmd_next = !diag_next ? 3'h0 :
		diag_large ? FRAG_CMD_LARGE : FRAG_CMD_SMALL;
	wire logic [2:0] diag_resp_next = !diag_next ? 3'h0 :
		diag_large ? FRAG_RESP_LARGE : FRAG_RESP_SMALL;
	wire logic [7:0] checksum_next = {4'h0, chip_period_select_reg} ^
		timing_config_two_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chip_period_select_reg <= CHIP_PERIOD_RESET;
			timing_config_two_reg <= CFG_TWO_RESET;
		end else begin
			chip_period_select_reg <= chip_period_next;
			timing_config_two_reg <= cfg_two_next;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_reg <= 8'h00;
			reg_err_reg <= 1'b0;
			checksum_reg <= 8'h00;
		end else begin
			reg_rdata_reg <= rdata_next;
			reg_err_reg <= refuse;
			checksum_reg <= checksum_next;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			period_tenths_reg <= 7'h00;
			slew_en_reg <= 1'b0;
			period_active_reg <= 1'b0;
			d19_reg <= 4'h0;
			d20_reg <= 4'h0;
		end else begin
			period_tenths_reg <= period_next;
			slew_en_reg <= slew_next;
			period_active_reg <= active_next;
			d19_reg <= d19_next;
			d20_reg <= d20_next;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cap_test_run_reg <= 1'b0;
			uv_reg <= 1'b0;
			diag_active_reg <= 1'b0;
			diag_cmd_reg <= 3'h0;
			diag_resp_reg <= 3'h0;
		end else begin
			cap_test_run_reg <= cap_run_next;
			uv_reg <= uv_next;
			diag_active_reg <= diag_next;
			diag_cmd_reg <= diag_cmd_next;
			diag_resp_reg <= diag_resp_next;
		end
	end

	assign reg_rdata_o = reg_rdata_reg;
	assign reg_err_o = reg_err_reg;
	assign period_tenths_o = period_tenths_reg;
	assign slew_en_o = slew_en_reg;
	assign period_active_o = period_active_reg;
	assign init2_d19_o = d19_reg;
	assign init2_d20_o = d20_reg;
	assign osc_train_error_flag_o = osc_bus.error_flag;
	assign cap_test_run_o = cap_test_run_reg;
	assign buffer_undervoltage_error_o = uv_reg;
	assign diag_active_o = diag_active_reg;
	assign diag_cmd_bits_o = diag_cmd_reg;
	assign diag_resp_chips_o = diag_resp_reg;
	assign rw_checksum_o = checksum_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_dsi3_low;
		(is_dsi3 && traffic_periodic_i && chip_period_select_reg < 4'h2) |=>
			!slew_en_o && period_tenths_o == ($past(chip_period_select_reg[0]) ? 7'h14 : 7'h0A);
	endproperty
	a_dsi3_low: assert property (p_dsi3_low) else $error("Low chip code wrong.");

	property p_dsi3_high;
		(is_dsi3 && traffic_periodic_i && chip_period_select_reg == 4'hC) |=>
			slew_en_o && period_tenths_o == 7'h23;
	endproperty
	a_dsi3_high: assert property (p_dsi3_high) else $error("Code 1100 not 3.5 us.");

	property p_crm;
		(is_dsi3 && !traffic_periodic_i) |=> slew_en_o && period_tenths_o == 7'h32;
	endproperty
	a_crm: assert property (p_crm) else $error("Command traffic not 5 us.");

	property p_psi5;
		is_psi5 |=> slew_en_o &&
			period_tenths_o == ($past(chip_period_select_reg[3]) ? 7'h50 : 7'h35);
	endproperty
	a_psi5: assert property (p_psi5) else $error("PSI5 bit time wrong.");

	property p_spi_inert;
		(mode_i == MODE_SPI || mode_i == MODE_I2C) |=> !period_active_o && !cap_test_run_o &&
			!diag_active_o && init2_d19_o == 4'h0;
	endproperty
	a_spi_inert: assert property (p_spi_inert) else $error("Serial mode has effect.");

	property p_access;
		(reg_wr_i && is_psi5) |=> reg_err_o &&
			timing_config_two_reg == $past(timing_config_two_reg);
	endproperty
	a_access: assert property (p_access) else $error("PSI5 write not refused.");

	property p_lock;
		(reg_wr_i && access_ok && hit_two && uv_reg && reg_wdata_i[CAP_OFF_BIT] &&
			!timing_config_two_reg[CAP_OFF_BIT]) |=> !timing_config_two_reg[CAP_OFF_BIT] ##1
			cap_test_run_o || !$past(is_dsi3);
	endproperty
	a_lock: assert property (p_lock) else $error("Disable write accepted.");

	property p_nibble;
		(is_psi5_any && nib_user) |=> init2_d19_o == $past(user_data_six_i[7:4]) &&
			init2_d20_o == $past(user_data_fourteen_i[7:4]);
	endproperty
	a_nibble: assert property (p_nibble) else $error("Nibble source wrong.");

	property p_reserved;
		timing_config_two_reg[RESERVED_BIT] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved bit set.");

	property p_frag;
		(is_dsi3 && timing_config_two_reg[1:0] == 2'b11) |=>
			diag_cmd_bits_o == 3'h4 && diag_resp_chips_o == 3'h6;
	endproperty
	a_frag: assert property (p_frag) else $error("Large fragment wrong.");

	property p_uv;
		(cap_fault_i && is_dsi3 && !timing_config_two_reg[CAP_OFF_BIT]) |=>
			buffer_undervoltage_error_o;
	endproperty
	a_uv: assert property (p_uv) else $error("Fault did not set error.");

	property p_dsi3_mid;
		(is_dsi3 && traffic_periodic_i && chip_period_select_reg == 4'h7) |=>
			slew_en_o && period_tenths_o == 7'h1D;
	endproperty
	a_dsi3_mid: assert property (p_dsi3_mid) else $error("Code 0111 not 2.9 us.");

	property p_refuse;
		(reg_rd_i && !access_ok) |=> reg_err_o && reg_rdata_o == 8'h00;
	endproperty
	a_refuse: assert property (p_refuse) else $error("Read outside access modes.");

	property p_nib_serial;
		(is_psi5_any && !nib_user) |=>
			{init2_d19_o, init2_d20_o} == $past(serial_number_byte4_i);
	endproperty
	a_nib_serial: assert property (p_nib_serial) else $error("Serial data wrong.");

	property p_cap_inert;
		!is_dsi3 |=> !cap_test_run_o;
	endproperty
	a_cap_inert: assert property (p_cap_inert) else $error("Test ran outside DSI3.");

	property p_frag_small;
		(is_dsi3 && timing_config_two_reg[1:0] == 2'b01) |=>
			diag_active_o && diag_cmd_bits_o == 3'h2 && diag_resp_chips_o == 3'h3;
	endproperty
	a_frag_small: assert property (p_frag_small) else $error("Small fragment.");

	property p_diag_off;
		!is_dsi3 |=> !diag_active_o && diag_cmd_bits_o == 3'h0;
	endproperty
	a_diag_off: assert property (p_diag_off) else $error("Diag outside DSI3.");

	c_lock: cover property (reg_wr_i && hit_two && lock_block && access_ok);
	c_psi5_slow: cover property (is_psi5 && chip_period_select_reg[3]);
	c_diag: cover property (diag_active_o && diag_resp_chips_o == 3'h6);

endmodule // bus_timing_config_decode
`default_nettype wire

// ---- hw/timing_cfg_pkg.sv ----
/*
 * Constants for the chip-period and second timing configuration decode.
 * Assumes a 25 MHz core clock derived from the trained oscillator.
 */
package timing_cfg_pkg;

	localparam logic [7:0] ADDR_CHIP_PERIOD = 8'h23;
	localparam logic [7:0] ADDR_CFG_TWO = 8'h24;
	localparam logic [3:0] CHIP_PERIOD_RESET = 4'h0;
	localparam logic [7:0] CFG_TWO_RESET = 8'h00;

	localparam int NIBBLE_SRC_BIT = 7;
	localparam int OSC_SEL_MSB = 6;
	localparam int OSC_SEL_LSB = 4;
	localparam int CAP_OFF_BIT = 3;
	localparam int RESERVED_BIT = 2;
	localparam int FRAG_SIZE_BIT = 1;
	localparam int DIAG_EN_BIT = 0;
	localparam logic [7:0] CFG_TWO_WMASK = 8'hFB;

	localparam logic [2:0] MODE_DSI3 = 3'h0;
	localparam logic [2:0] MODE_PSI5 = 3'h1;
	localparam logic [2:0] MODE_PSI5_PROG = 3'h2;
	localparam logic [2:0] MODE_SPI = 3'h3;
	localparam logic [2:0] MODE_I2C = 3'h4;

	// Chip and bit periods in tenths of a microsecond.
	localparam logic [6:0] DSI3_CHIP_TENTHS [16] = '{
		7'h0A, 7'h14, 7'h19, 7'h1A, 7'h1A, 7'h1B, 7'h1C, 7'h1D,
		7'h1E, 7'h1F, 7'h20, 7'h21, 7'h23, 7'h28, 7'h2D, 7'h32};
	localparam logic [6:0] CRM_CHIP_TENTHS = 7'h32;
	localparam logic [6:0] PSI5_FAST_TENTHS = 7'h35;
	localparam logic [6:0] PSI5_SLOW_TENTHS = 7'h50;
	localparam logic [3:0] DSI3_SLEW_FIRST_CODE = 4'h2;

	localparam logic [2:0] FRAG_CMD_SMALL = 3'h2;
	localparam logic [2:0] FRAG_RESP_SMALL = 3'h3;
	localparam logic [2:0] FRAG_CMD_LARGE = 3'h4;
	localparam logic [2:0] FRAG_RESP_LARGE = 3'h6;

	localparam int CLK_MHZ = 25;
	localparam int OSC_PERIOD_US = 4000;
	localparam int OSC_PERIOD_CYCLES = OSC_PERIOD_US * CLK_MHZ;
	localparam logic [6:0] OSC_MAX_PERIODS = 7'h40;

	function automatic logic [6:0] osc_target(input logic [2:0] sel);
		osc_target = (sel == 3'h0) ? OSC_MAX_PERIODS : (7'h01 << (sel - 3'h1));
	endfunction

endpackage

// ---- hw/osc_timer_if.sv ----
/*
 * Carries the oscillator-training timeout controls and the error flag.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface osc_timer_if;
	logic run;
	logic clear;
	logic [2:0] sel;
	logic error_flag;
	modport timer (input run, input clear, input sel, output error_flag);
	modport ctrl (output run, output clear, output sel, input error_flag);
endinterface
`default_nettype wire

// ---- hw/osc_train_timer.sv ----
/*
 * Counts 4 ms periods while oscillator training runs and raises the error flag.
 * Assumes a synchronous run level and a clear pulse from the register block.
 */
`timescale 1ns/10ps
`default_nettype none
module osc_train_timer
	import timing_cfg_pkg::*;
#(
	parameter int TICK_CYCLES = OSC_PERIOD_CYCLES
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	osc_timer_if.timer tmr
);
	logic [16:0] tick_cnt_reg;
	logic [6:0] period_cnt_reg;
	logic flag_reg;
	wire logic tick_done = (tick_cnt_reg == 17'(TICK_CYCLES - 1));
	wire logic reach = tick_done && ((period_cnt_reg + 7'h01) == osc_target(tmr.sel));
	wire logic [16:0] tick_cnt_next = (!tmr.run || tmr.clear || tick_done) ? 17'h0 :
		tick_cnt_reg + 17'h1;
	wire logic [6:0] period_cnt_next = (!tmr.run || tmr.clear) ? 7'h00 :
		(tick_done && !flag_reg) ? period_cnt_reg + 7'h01 : period_cnt_reg;
	// A set in the cycle of a clear wins.
	wire logic flag_next = (tmr.run && reach) || (flag_reg && !tmr.clear);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt_reg <= 17'h0;
			period_cnt_reg <= 7'h00;
			flag_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			period_cnt_reg <= period_cnt_next;
			flag_reg <= flag_next;
		end
	end

	assign tmr.error_flag = flag_reg;

	property p_osc_rise;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(flag_reg) |-> $past(tmr.run) && $past(tick_done) &&
			($past(period_cnt_reg) + 7'h01) == osc_target($past(tmr.sel));
	endproperty
	a_osc_rise: assert property (p_osc_rise) else $error("Training flag rose early.");

	c_osc_set: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(flag_reg));

endmodule // osc_train_timer
`default_nettype wire

// ---- tb/bus_master_model.sv ----
/*
 * Bus master model that issues single-byte register accesses.
 * Assumes the device samples its strobes on the rising core clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Holds one access for one cycle, then leaves inverted values on the released bus.
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= w;
		rd_o <= !w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
endmodule // bus_master_model
`default_nettype wire

// ---- tb/bus_timing_config_decode_tb.sv ----
/*
 * Self-checking bench for the timing configuration decode block.
 * Assumes the bus master model and a shortened training period.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bus_timing_config_decode_tb;
	import timing_cfg_pkg::*;
	localparam int TICKS = 4;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [2:0] mode = MODE_DSI3;
	logic periodic = 1'b1;
	logic [7:0] sn = 8'h00;
	logic [7:0] ud6 = 8'h00;
	logic [7:0] ud14 = 8'h00;
	logic run = 1'b0;
	logic clr = 1'b0;
	logic fault = 1'b0;
	wire logic [7:0] addr, wdata, rdata, csum;
	wire logic wr, rd, err, slew, pact, oflag, ctr, buv, dact;
	wire logic [6:0] per;
	wire logic [3:0] d19, d20;
	wire logic [2:0] dcmd, dresp;
	logic [8:0] exp_q [$];
	logic [8:0] note;
	logic acc_d = 1'b0;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	int n;
	logic [31:0] rnd = 32'hB060;
	logic [3:0] cp = 4'h0;
	logic [7:0] c2 = 8'h00;
	int tbl [16] = '{10, 20, 25, 26, 26, 27, 28, 29, 30, 31, 32, 33, 35, 40, 45, 50};

	always #20 clk_i = ~clk_i;

	bus_master_model m (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	bus_timing_config_decode #(.TICK_CYCLES(TICKS)) dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_i(mode), .traffic_periodic_i(periodic),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.serial_number_byte4_i(sn), .user_data_six_i(ud6), .user_data_fourteen_i(ud14),
		.osc_train_run_i(run), .osc_train_clear_i(clr), .cap_fault_i(fault),
		.reg_rdata_o(rdata), .reg_err_o(err), .period_tenths_o(per), .slew_en_o(slew),
		.period_active_o(pact), .init2_d19_o(d19), .init2_d20_o(d20),
		.osc_train_error_flag_o(oflag), .cap_test_run_o(ctr),
		.buffer_undervoltage_error_o(buv), .diag_active_o(dact), .diag_cmd_bits_o(dcmd),
		.diag_resp_chips_o(dresp), .rw_checksum_o(csum));

	function automatic logic [7:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd[7:0];
	endfunction

	task automatic stop_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic e);
		exp_q.push_back({e, 8'h00});
		m.access(1'b1, a, d);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] x, input logic e);
		exp_q.push_back({e, e ? 8'h00 : x});
		m.access(1'b0, a, 8'h00);
	endtask

	task automatic set_cp(input logic [3:0] v);
		wr_reg(8'h23, {4'h0, v}, 1'b0);
		cp = v;
	endtask

	task automatic set_c2(input logic [7:0] v);
		wr_reg(8'h24, v, 1'b0);
		c2 = v & 8'hFB;
	endtask

	task automatic settle;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(csum, {4'h0, cp} ^ c2)
	endtask

	task automatic go(input logic [2:0] md, input logic pe);
		@(posedge clk_i);
		mode <= md;
		periodic <= pe;
		settle;
	endtask

	always @(posedge clk_i) begin
		acc_d <= wr | rd;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			stop_test;
		end
	end

	always @(negedge clk_i) begin
		if (acc_d) begin
			note = exp_q.pop_front();
			`CHK({err, rdata}, note)
		end
	end

	initial begin
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd_reg(8'h23, 8'h00, 1'b0);
		rd_reg(8'h24, 8'h00, 1'b0);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			set_cp(c[3:0]);
			go(MODE_DSI3, 1'b1);
			`CHK({pact, slew, per}, {1'b1, c > 1, 7'(tbl[c])})
			go(MODE_DSI3, 1'b0);
			`CHK({slew, per}, {1'b1, 7'h32})
			go(MODE_PSI5, 1'b1);
			`CHK({slew, per}, {1'b1, c[3] ? 7'h50 : 7'h35})
			go(MODE_SPI, 1'b1);
			`CHK(pact, 1'b0)
			rd_reg(8'h23, {4'h0, c[3:0]}, 1'b0);
		end
		$display("test chip period done");
		go(MODE_PSI5, 1'b1);
		rd_reg(8'h24, 8'h00, 1'b1);
		wr_reg(8'h24, 8'h01, 1'b1);
		go(3'h5, 1'b1);
		rd_reg(8'h23, 8'h00, 1'b1);
		go(MODE_I2C, 1'b1);
		rd_reg(8'h30, 8'h00, 1'b1);
		set_c2(8'hFF);
		rd_reg(8'h24, 8'hFB, 1'b0);
		go(MODE_PSI5_PROG, 1'b1);
		rd_reg(8'h24, 8'hFB, 1'b0);
		$display("test access done");
		for (int b = 0; b < 2; b++) begin
			@(posedge clk_i);
			sn <= xs();
			ud6 <= xs();
			ud14 <= xs();
			go(MODE_DSI3, 1'b1);
			set_c2({b[0], 7'h00});
			settle;
			`CHK({d19, d20}, 8'h00)
			go(MODE_PSI5, 1'b1);
			`CHK({d19, d20}, b ? {ud6[7:4], ud14[7:4]} : sn)
			go(MODE_PSI5_PROG, 1'b1);
			`CHK({pact, d19, d20}, {1'b0, b ? {ud6[7:4], ud14[7:4]} : sn})
		end
		$display("test nibble source done");
		go(MODE_DSI3, 1'b1);
		set_c2(8'h00);
		settle;
		`CHK(ctr, 1'b1)
		@(posedge clk_i);
		fault <= 1'b1;
		settle;
		`CHK(buv, 1'b1)
		wr_reg(8'h24, 8'h08, 1'b1);
		rd_reg(8'h24, 8'h00, 1'b0);
		set_c2(8'h02);
		@(posedge clk_i);
		fault <= 1'b0;
		settle;
		`CHK(buv, 1'b0)
		set_c2(8'h08);
		settle;
		`CHK(ctr, 1'b0)
		go(MODE_SPI, 1'b1);
		set_c2(8'h00);
		settle;
		`CHK(ctr, 1'b0)
		$display("test capacitor done");
		for (int v = 0; v < 4; v++) begin
			set_c2({6'h00, v[1:0]});
			go(MODE_DSI3, 1'b1);
			`CHK(dact, v[0])
			`CHK({dcmd, dresp}, v == 1 ? 6'h13 : (v == 3 ? 6'h26 : 6'h00))
			go(MODE_SPI, 1'b1);
			`CHK(dact, 1'b0)
		end
		$display("test diagnostic done");
		for (int k = 0; k < 4; k++) begin
			set_c2({1'b0, k[2:0], 4'h0});
			n = (k == 0) ? 64 : (1 << (k - 1));
			@(posedge clk_i);
			clr <= 1'b1;
			@(posedge clk_i);
			clr <= 1'b0;
			run <= 1'b1;
			repeat (n * TICKS - 2) @(posedge clk_i);
			@(negedge clk_i);
			`CHK(oflag, 1'b0)
			repeat (4) @(posedge clk_i);
			@(negedge clk_i);
			`CHK(oflag, 1'b1)
			@(posedge clk_i);
			run <= 1'b0;
		end
		$display("test training timeout done");
		repeat (2) @(negedge clk_i);
		`CHK(exp_q.size() == 0, 1'b1)
		stop_test;
	end
endmodule // bus_timing_config_decode_tb
`default_nettype wire
